// ### hdl/slw_watchdog.sv
`timescale 1ns/10ps
// Contract
// - On detected link loss raise the link-loss alarm and cut the output.
// - Check only when the interval setting is 0.1 s to 999.8 s.
// - Any received frame clears the counter, whatever its station number.
// - Timing starts at the first frame after entering network mode.
// - A setting of 9999 disables the silence check entirely.
// - A setting of 0 trips the alarm on entry to network mode.
// - Measured silence includes the 3.5 character idle gap.
module slw_watchdog #(
    parameter int STEP_CYCLES = slw_pkg::STEP_CYCLES
) (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic frame_rx_in,
    input wire logic net_mode_in,
    input wire logic [slw_pkg::SETTING_W-1:0]
        link_check_interval_setting_in,
    output logic serial_link_loss_alarm_out,
    output logic output_enable_out,
    output logic timing_active_out
);
    import slw_pkg::*;

    // ------------------------------------------------------------
    // 0.1 s time base
    // ------------------------------------------------------------
    // Kept in its own module so the divider length can be set by STEP_CYCLES
    slw_step_if step_if ();

    slw_step_gen #(
        .STEP_CYCLES(STEP_CYCLES)
    ) u_step (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .step_if(step_if)
    );

    // ------------------------------------------------------------
    // Setting decode
    // ------------------------------------------------------------
    function automatic logic check_enabled(input logic [13:0] s);
        return (s >= SET_MIN_CHECK) && (s <= SET_MAX_CHECK);
    endfunction

    function automatic logic trips_on_entry(input logic [13:0] s);
        return s == SET_TRIP_ON_ENTRY;
    endfunction

    // Count above the setting means a whole interval went by silent
    function automatic logic silence_expired(
        input logic [13:0] cnt,
        input logic [13:0] s
    );
        return cnt > s;
    endfunction

    // ------------------------------------------------------------
    // Internal state
    // ------------------------------------------------------------
    slw_state_type state_ff;
    slw_state_type nxt_state;
    logic net_mode_d_ff;
    logic [SETTING_W-1:0] count_ff;
    logic [SETTING_W-1:0] nxt_count;
    logic alarm_ff;
    logic out_en_ff;
    logic timing_ff;
    logic enter_net;
    logic check_on;
    logic trip;
    logic entry_trip;
    logic silence_trip;
    logic frame_clears;

    // ------------------------------------------------------------
    // Trip conditions
    // ------------------------------------------------------------
    assign enter_net = net_mode_in && !net_mode_d_ff;
    assign check_on = check_enabled(link_check_interval_setting_in);
    assign frame_clears = frame_rx_in || state_ff != SLW_TIMING;

    // Only the rising edge of network mode trips a zero setting
    assign entry_trip = enter_net &&
        trips_on_entry(link_check_interval_setting_in);

    // Frame end marks the restart, so the idle gap is counted
    assign silence_trip = state_ff == SLW_TIMING && check_on &&
        !frame_rx_in &&
        silence_expired(count_ff, link_check_interval_setting_in);

    always_comb begin
        trip = 1'b0;
        if (entry_trip) begin
            trip = 1'b1;
        end else if (silence_trip) begin
            trip = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Sequencing
    // ------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            SLW_IDLE: begin
                if (net_mode_in) begin
                    nxt_state = SLW_WAIT_FIRST;
                end
            end
            SLW_WAIT_FIRST: begin
                if (!net_mode_in) begin
                    nxt_state = SLW_IDLE;
                end else if (frame_rx_in) begin
                    nxt_state = SLW_TIMING;
                end
            end
            SLW_TIMING: begin
                if (!net_mode_in) begin
                    nxt_state = SLW_IDLE;
                end
            end
            SLW_TRIPPED: begin
                // Only reset leaves this state
                nxt_state = SLW_TRIPPED;
            end
            default: begin
                nxt_state = SLW_TRIPPED;
            end
        endcase
        if (trip) begin
            nxt_state = SLW_TRIPPED;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            state_ff <= SLW_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ------------------------------------------------------------
    // Network mode edge
    // ------------------------------------------------------------
    // Resets low, so leaving reset in network mode counts as entry
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            net_mode_d_ff <= 1'b0;
        end else begin
            net_mode_d_ff <= net_mode_in;
        end
    end

    // ------------------------------------------------------------
    // Silence counter
    // ------------------------------------------------------------
    // Divider restarts with the counter so each step is a full 0.1 s
    assign step_if.restart = frame_clears;

    // Saturates rather than wraps, so a stuck count still trips
    always_comb begin
        nxt_count = count_ff;
        if (frame_clears) begin
            nxt_count = COUNT_RESET;
        end else if (step_if.step && count_ff != COUNT_MAX) begin
            nxt_count = count_ff + 1'b1;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            count_ff <= COUNT_RESET;
        end else begin
            count_ff <= nxt_count;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Alarm and cut share one trip term so they never disagree
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            alarm_ff <= 1'b0;
        end else if (trip) begin
            alarm_ff <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            out_en_ff <= 1'b1;
        end else if (trip) begin
            out_en_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Status
    // ------------------------------------------------------------
    // High from the first frame until trip or leaving network mode
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            timing_ff <= 1'b0;
        end else begin
            timing_ff <= (nxt_state == SLW_TIMING);
        end
    end

    // ------------------------------------------------------------
    // Port drivers
    // ------------------------------------------------------------
    assign serial_link_loss_alarm_out = alarm_ff;
    assign output_enable_out = out_en_ff;
    assign timing_active_out = timing_ff;
endmodule

// ### hdl/slw_pkg.sv
package slw_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int STEP_TIME_NS = 100_000_000;
    localparam int STEP_CYCLES = STEP_TIME_NS / CLK_PERIOD_NS;
    localparam int STEP_CNT_W = 23;

    // ------------------------------------------------------------
    // Interval setting, in units of 0.1 s
    // ------------------------------------------------------------
    localparam int SETTING_W = 14;
    localparam logic [13:0] SET_TRIP_ON_ENTRY = 14'h0000;
    localparam logic [13:0] SET_MIN_CHECK = 14'h0001;
    localparam logic [13:0] SET_MAX_CHECK = 14'h270E;
    localparam logic [13:0] SET_NO_CHECK = 14'h270F;
    localparam logic [13:0] COUNT_RESET = 14'h0000;
    localparam logic [13:0] COUNT_MAX = 14'h3FFF;

    typedef enum logic [1:0] {
        SLW_IDLE,
        SLW_WAIT_FIRST,
        SLW_TIMING,
        SLW_TRIPPED
    } slw_state_type;
endpackage

// ### hdl/slw_step_if.sv
`timescale 1ns/10ps
interface slw_step_if;
    logic restart;
    logic step;
    modport ctrl (output restart, input step);
    modport gen (input restart, output step);
endinterface

// ### hdl/slw_step_gen.sv
`timescale 1ns/10ps
module slw_step_gen #(
    parameter int STEP_CYCLES = slw_pkg::STEP_CYCLES
) (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    slw_step_if.gen step_if
);
    import slw_pkg::*;

    localparam logic [STEP_CNT_W-1:0] LAST =
        STEP_CNT_W'(STEP_CYCLES - 1);

    logic [STEP_CNT_W-1:0] div_ff;
    logic step_ff;

    // ------------------------------------------------------------
    // 0.1 s divider, realigned on every frame
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_in) begin
        if (rst_in || step_if.restart) begin
            div_ff <= '0;
        end else if (div_ff == LAST) begin
            div_ff <= '0;
        end else begin
            div_ff <= div_ff + 1'b1;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in || step_if.restart) begin
            step_ff <= 1'b0;
        end else begin
            step_ff <= (div_ff == LAST);
        end
    end

    assign step_if.step = step_ff;
endmodule

// ### verification/slw_assertions.sv
`timescale 1ns/10ps
module slw_assertions #(
    parameter int STEP_CYCLES = 4
) (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic frame_rx_in,
    input wire logic net_mode_in,
    input wire logic [slw_pkg::SETTING_W-1:0]
        link_check_interval_setting_in,
    input wire logic serial_link_loss_alarm_out,
    input wire logic output_enable_out,
    input wire logic timing_active_out
);
    import slw_pkg::*;
    wire al = serial_link_loss_alarm_out;
    wire [13:0] st = link_check_interval_setting_in;
    int quiet_ff;
    int lim;
    assign lim = (int'(st) + 1) * STEP_CYCLES;
    // Silence seen on the wire, independent of the design's own counter
    always_ff @(posedge clk_sys_in)
        quiet_ff <= (rst_in || frame_rx_in) ? 0 : quiet_ff + 1;
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    sequence s_entry;
        net_mode_in && !$past(net_mode_in);
    endsequence
    a_entry_trip: assert property (
        s_entry ##0 st == SET_TRIP_ON_ENTRY |=> al) else $error("no entry trip");
    a_alarm_latch: assert property (
        al |=> al) else $error("alarm dropped");
    a_output_cut: assert property (
        output_enable_out != al) else $error("output not cut");
    a_no_check: assert property (
        st == SET_NO_CHECK && !al |=> !al) else $error("trip with no check");
    a_start_frame: assert property (
        $rose(timing_active_out) |-> $past(frame_rx_in && net_mode_in))
        else $error("timing without frame");
    a_frame_clear: assert property (
        frame_rx_in && timing_active_out |=> !al [*6])
        else $error("trip soon after frame");
    a_trip_late: assert property (
        timing_active_out && st < SET_NO_CHECK |-> quiet_ff <= lim + 4)
        else $error("trip too late");
    a_trip_early: assert property (
        $rose(al) && st != SET_TRIP_ON_ENTRY |-> quiet_ff >= lim - 2)
        else $error("trip too early");
endmodule

bind slw_watchdog slw_assertions #(.STEP_CYCLES(STEP_CYCLES)) u_chk (.*);

// ### verification/slw_master_model.sv
`timescale 1ns/10ps
module slw_master_model (
    input wire logic clk_sys_in,
    input wire logic [15:0] gap_in,
    output logic frame_out
);
    int cnt = 0;
    initial frame_out = 1'b0;
    // A gap of zero models a master that has gone silent
    always @(posedge clk_sys_in) begin
        frame_out <= gap_in != 16'h0000 && cnt >= int'(gap_in);
        cnt <= (cnt >= int'(gap_in)) ? 0 : cnt + 1;
    end
endmodule

// ### verification/serial_link_loss_watchdog_tb.sv
`timescale 1ns/10ps
module serial_link_loss_watchdog_tb;
    import slw_pkg::*;
    localparam int STEP = 4;
    logic clk_sys_in = 1'b0;
    logic rst_in = 1'b1;
    logic net_mode = 1'b0;
    logic [SETTING_W-1:0] set_val = 14'h0000;
    logic [15:0] gap = 16'h0000;
    logic frame_rx, alarm, out_en, timing, ok;
    int num_errors = 0;
    int samples_checked = 0;
    int seed = 32'h3F4D5950;
    int s, n, g;
    slw_watchdog #(.STEP_CYCLES(STEP)) u_slw_watchdog (.clk_sys_in(clk_sys_in),
        .rst_in(rst_in), .frame_rx_in(frame_rx), .net_mode_in(net_mode),
        .link_check_interval_setting_in(set_val),
        .serial_link_loss_alarm_out(alarm), .output_enable_out(out_en),
        .timing_active_out(timing));
    slw_master_model u_slw_master_model (.clk_sys_in(clk_sys_in),
        .gap_in(gap), .frame_out(frame_rx));
    initial forever #10 clk_sys_in = ~clk_sys_in;
    task automatic tick(input int k);
        repeat (k) @(posedge clk_sys_in);
        #1;
    endtask
    task automatic chk(input string nm, input logic e, input logic v);
        samples_checked++;
        if (v !== e) begin
            num_errors++;
            $display("Error %s expected %b seen %b", nm, e, v);
        end
    endtask
    task automatic restart(input int st);
        rst_in = 1'b1;
        net_mode = 1'b0;
        gap = 16'h0000;
        set_val = st[13:0];
        tick(2);
        rst_in = 1'b0;
        chk("reset enable", 1'b1, out_en);
    endtask
    task automatic stop_test;
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #200000;
        num_errors++;
        stop_test();
    end
    initial begin
        for (int i = 0; i < 3; i++) begin
            s = 1 + ($unsigned($random(seed)) % 3);
            restart(s);
            net_mode = 1'b1;
            g = 1 + ($unsigned($random(seed)) % ((s + 1) * STEP - 3));
            gap = 16'(g);
            tick(60);
            chk("quiet alarm", 1'b0, alarm);
            chk("timing", 1'b1, timing);
            gap = 16'h0000;
            n = 0;
            while (alarm !== 1'b1 && n < 200) begin
                tick(1);
                n++;
            end
            ok = n >= (s + 1) * STEP - g - 2 && n <= (s + 1) * STEP + 6;
            chk("trip delay", 1'b1, ok);
            chk("output cut", 1'b0, out_en);
            gap = 16'h0001;
            net_mode = 1'b0;
            tick(20);
            chk("latched", 1'b1, alarm);
            $display("done: silence trip %0d", s);
        end
        restart(1);
        net_mode = 1'b1;
        tick(40);
        chk("no first frame", 1'b0, alarm);
        chk("no timing", 1'b0, timing);
        $display("done: wait first frame");
        restart(9999);
        net_mode = 1'b1;
        gap = 16'h0002;
        tick(10);
        gap = 16'h0000;
        tick(200);
        chk("no check", 1'b0, alarm);
        $display("done: no check");
        restart(0);
        gap = 16'h0001;
        tick(3);
        net_mode = 1'b1;
        tick(1);
        chk("entry trip", 1'b1, alarm);
        $display("done: entry trip");
        stop_test();
    end
endmodule
